//--- rtl/mac_misc_flow_ctrl_regs.sv
/*
 * MAC miscellaneous control/status registers with flow-control refresh logic,
 * reached over AXI4-Lite.
 * Assumes all status and event inputs are on aclk; the PHY pins pass a
 * three-stage synchroniser here. lan_reset_n, pci_reset_n and d3_to_d0 are
 * synchronous to aclk.
 * Offsets are byte addresses; address bits 1:0 are ignored.
 * Slot length is fixed at build time, so refresh cannot follow link speed.
 * The RAM lock is sticky; software cannot clear it, only a reset.
 */
// Notes on behaviour
// - Extension register reset only by LAN reset.
// - Cable-unplugged status shows on bit 2.
// - Bit 3 shows external PHY power.
// - Bit 7 repeats XOFF while transmitter paused.
// - Bit 8 pulses trigger on CRC mismatch.
// - Trigger ignored while CRC offloaded to hardware.
// - Bit 9 locks RAM writes until reset.
// - Function number reads zero.
// - Device number reads twenty-five.
// - Bus number captured on type 0 write.
// - Bus number cleared by three resets.
// - Timer value goes into pause frames.
// - Pause time counts in 64-byte slots.
// - Refresh threshold reached resends XOFF when full.
// - Refresh counter advances once per slot.
// - Zero threshold disables refresh.
// - Threshold upper bits read zero.
`timescale 1ns/100ps
module mac_misc_flow_ctrl_regs
	import mac_misc_pkg::*;
#(
	parameter int ADDR_WIDTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic lan_reset_n,
	input wire logic pci_reset_n,
	input wire logic d3_to_d0,

	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,

	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,

	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,

	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,

	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,

	input wire logic cable_unplugged_pin,
	input wire logic phy_power_pin,
	input wire logic cfg_type0_write,
	input wire logic [7:0] cfg_bus_number,

	input wire logic crc_mismatch,
	input wire logic crc_hw_offload,

	input wire logic tx_paused,
	input wire logic rx_above_low_threshold,
	input wire logic xoff_sent,

	output logic xoff_request,
	output logic crc_mismatch_trigger,
	output logic ram_write_lock,
	output logic [15:0] pause_time_value,
	output logic [15:0] pause_slot_pulse
);

	localparam int SLOT_CNT_W = $clog2(SLOT_CYCLES + 1);

	// One-hot register select, shared by the read and write decoders
	typedef enum logic [4:0] {
		SEL_NONE = 5'b00001,
		SEL_EXT = 5'b00010,
		SEL_LOC = 5'b00100,
		SEL_TIMER = 5'b01000,
		SEL_THRESH = 5'b10000
	} reg_sel_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [ADDR_WIDTH-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;

		logic bvalid;
		logic [1:0] bresp;

		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;

		logic [2:0] cab_sync;
		logic [2:0] pwr_sync;
		logic cable_unplugged_flag;
		logic phy_power_status;

		logic [2:0] future_ctrl;
		logic [7:0] bus_number;
		logic [15:0] pause_timer;
		logic [15:0] refresh_threshold_value;

		logic [SLOT_CNT_W-1:0] slot_cnt;
		logic slot_tick;
		logic [15:0] refresh_cnt;

		logic xoff_request;
		logic crc_trigger;
		logic ram_lock;
	} state_t;

	state_t state_reg;
	state_t state_next;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
		logic [15:0] w;
		w = 16'(a) & 16'hFFFC;
		return (w == FUTURE_EXTENSION_CONTROL_OFFSET) || (w == PCI_LOCATION_CAPTURE_OFFSET) ||
			(w == PAUSE_TRANSMIT_TIMER_OFFSET) || (w == PAUSE_REFRESH_THRESHOLD_OFFSET);
	endfunction : is_mapped

	function automatic reg_sel_t decode_reg(input logic [15:0] a);
		reg_sel_t sel;
		case (a & 16'hFFFC)
			FUTURE_EXTENSION_CONTROL_OFFSET: begin
				sel = SEL_EXT;
			end
			PCI_LOCATION_CAPTURE_OFFSET: begin
				sel = SEL_LOC;
			end
			PAUSE_TRANSMIT_TIMER_OFFSET: begin
				sel = SEL_TIMER;
			end
			PAUSE_REFRESH_THRESHOLD_OFFSET: begin
				sel = SEL_THRESH;
			end
			default: begin
				sel = SEL_NONE;
			end
		endcase
		return sel;
	endfunction : decode_reg

	// Three-stage pin synchroniser; a level counts once stages two and three agree
	function automatic logic [2:0] sync_shift(input logic [2:0] s, input logic pin);
		return {s[1:0], pin};
	endfunction : sync_shift

	function automatic logic sync_settled(input logic [2:0] s);
		return s[1] == s[2];
	endfunction : sync_settled

	function automatic logic [31:0] read_word(input state_t s, input reg_sel_t sel);
		logic [31:0] rv;
		rv = 32'h0000_0000;
		case (sel)
			SEL_EXT: begin
				rv[CABLE_UNPLUGGED_BIT] = s.cable_unplugged_flag;
				rv[PHY_POWER_BIT] = s.phy_power_status;
				rv[RAM_LOCK_EN_BIT:XOFF_ON_PAUSE_BIT] = s.future_ctrl;
			end
			SEL_LOC: begin
				rv[FUNCTION_LSB +: 3] = FUNCTION_NUMBER;
				rv[DEVICE_LSB +: 5] = DEVICE_NUMBER;
				rv[BUS_LSB +: 8] = s.bus_number;
			end
			SEL_TIMER: begin
				rv[15:0] = s.pause_timer;
			end
			SEL_THRESH: begin
				// Upper half stays zero whatever software wrote there
				rv[15:0] = s.refresh_threshold_value;
			end
			default: begin
				rv = 32'h0000_0000;
			end
		endcase
		return rv;
	endfunction : read_word

	always_comb begin
		logic [31:0] cur;
		logic [31:0] wv;
		logic [15:0] waddr;
		logic [15:0] raddr;
		reg_sel_t wsel;
		reg_sel_t rsel;
		cur = 32'h0000_0000;
		wv = 32'h0000_0000;
		waddr = 16'(state_reg.awaddr) & 16'hFFFC;
		raddr = 16'(s_axi_araddr) & 16'hFFFC;
		wsel = decode_reg(waddr);
		rsel = decode_reg(raddr);
		state_next = state_reg;

		// Pin inputs: change accepted once stages two and three agree
		state_next.cab_sync = sync_shift(state_reg.cab_sync, cable_unplugged_pin);
		state_next.pwr_sync = sync_shift(state_reg.pwr_sync, phy_power_pin);
		if (sync_settled(state_reg.cab_sync)) begin
			// Unplug report only counts while the PHY is powered
			state_next.cable_unplugged_flag = state_reg.cab_sync[2] & state_reg.phy_power_status;
		end
		if (sync_settled(state_reg.pwr_sync)) begin
			state_next.phy_power_status = state_reg.pwr_sync[2];
		end

		// Write channel: address and data taken independently
		if (s_axi_awvalid && state_reg.awready) begin
			state_next.awaddr = s_axi_awaddr;
			state_next.aw_held = 1'b1;
			state_next.awready = 1'b0;
		end

		if (s_axi_wvalid && state_reg.wready) begin
			state_next.wdata = s_axi_wdata;
			state_next.wstrb = s_axi_wstrb;
			state_next.w_held = 1'b1;
			state_next.wready = 1'b0;
		end

		// Response waits for both halves, so either order of arrival works
		if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = is_mapped(state_reg.awaddr) ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
			if (wsel == SEL_EXT) begin
				cur = 32'(state_reg.future_ctrl) << XOFF_ON_PAUSE_BIT;
				wv = merge_bytes(cur, state_reg.wdata, state_reg.wstrb);
				state_next.future_ctrl = wv[RAM_LOCK_EN_BIT:XOFF_ON_PAUSE_BIT];
			end
			if (wsel == SEL_TIMER) begin
				wv = merge_bytes({16'h0000, state_reg.pause_timer}, state_reg.wdata, state_reg.wstrb);
				state_next.pause_timer = wv[15:0];
			end
			if (wsel == SEL_THRESH) begin
				wv = merge_bytes({16'h0000, state_reg.refresh_threshold_value}, state_reg.wdata,
					state_reg.wstrb);
				state_next.refresh_threshold_value = wv[15:0];
			end
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
			state_next.awready = 1'b1;
			state_next.wready = 1'b1;
		end

		// Read channel: one-cycle answer after address taken
		if (s_axi_arvalid && state_reg.arready) begin
			state_next.arready = 1'b0;
			state_next.rvalid = 1'b1;
			state_next.rresp = is_mapped(s_axi_araddr) ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
			state_next.rdata = read_word(state_reg, rsel);
		end
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
			state_next.arready = 1'b1;
		end

		if (cfg_type0_write) begin
			state_next.bus_number = cfg_bus_number;
		end
		// Clear follows capture, so a reset in the same cycle wins
		if (!pci_reset_n || d3_to_d0) begin
			state_next.bus_number = BUS_NUMBER_RESET;
		end

		// Slot timebase shared by the pause and refresh timers
		// Whole cycles only, so a slot is slightly short of 512 ns
		state_next.slot_tick = 1'b0;
		if (state_reg.slot_cnt == SLOT_CNT_W'(SLOT_CYCLES - 1)) begin
			state_next.slot_cnt = '0;
			state_next.slot_tick = 1'b1;
		end else begin
			state_next.slot_cnt = state_reg.slot_cnt + SLOT_CNT_W'(1);
		end

		// Refresh counter: held at zero while the receive buffer is not above its low threshold, or when disabled
		state_next.xoff_request = 1'b0;
		// A drained buffer or zero threshold clears the count, so no stale count fires later
		if (!rx_above_low_threshold || state_reg.refresh_threshold_value == 16'h0000) begin
			state_next.refresh_cnt = 16'h0000;
		// A sent XOFF restarts the count, so a refresh waits a full threshold after it
		end else if (xoff_sent) begin
			state_next.refresh_cnt = 16'h0000;
		end else if (state_reg.refresh_cnt == state_reg.refresh_threshold_value) begin
			state_next.xoff_request = 1'b1;
			state_next.refresh_cnt = 16'h0000;
		end else if (state_reg.slot_tick) begin
			state_next.refresh_cnt = state_reg.refresh_cnt + 16'h0001;
		end
		// Repeat XOFF each slot while paused, when enabled
		if (state_reg.future_ctrl[0] && tx_paused && state_reg.slot_tick) begin
			state_next.xoff_request = 1'b1;
		end

		state_next.crc_trigger = crc_mismatch && state_reg.future_ctrl[1] && !crc_hw_offload;
		// Lock is sticky; only a reset releases it
		if (crc_mismatch && state_reg.future_ctrl[2]) begin
			state_next.ram_lock = 1'b1;
		end

		// LAN reset last, so it overrides every update above to the extension bits, bus number and lock
		if (!lan_reset_n) begin
			state_next.future_ctrl = FUTURE_CTRL_RESET;
			state_next.bus_number = BUS_NUMBER_RESET;
			state_next.ram_lock = 1'b0;
		end
	end

	// Power-on reset implies a LAN reset, so it clears the extension bits too
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			state_reg.awready <= 1'b1;
			state_reg.wready <= 1'b1;
			state_reg.arready <= 1'b1;
			state_reg.future_ctrl <= FUTURE_CTRL_RESET;
			state_reg.pause_timer <= PAUSE_TIMER_RESET;
			state_reg.refresh_threshold_value <= REFRESH_THRESHOLD_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign s_axi_awready = state_reg.awready;
	assign s_axi_wready = state_reg.wready;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = state_reg.arready;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign xoff_request = state_reg.xoff_request;
	assign crc_mismatch_trigger = state_reg.crc_trigger;
	assign ram_write_lock = state_reg.ram_lock;
	assign pause_time_value = state_reg.pause_timer;
	// Bits above the tick are tied low; the port keeps its width for later use
	assign pause_slot_pulse = {15'h0000, state_reg.slot_tick};

endmodule : mac_misc_flow_ctrl_regs

//--- pkg/mac_misc_pkg.sv
/*
 * Register map, field positions, reset values and timing constants for the
 * MAC miscellaneous flow-control register bank.
 * Assumes a 32-bit AXI4-Lite register bus and a 100 MHz clock.
 */
package mac_misc_pkg;

	localparam logic [15:0] FUTURE_EXTENSION_CONTROL_OFFSET = 16'h002C;
	localparam logic [15:0] PCI_LOCATION_CAPTURE_OFFSET = 16'h0038;
	localparam logic [15:0] PAUSE_TRANSMIT_TIMER_OFFSET = 16'h0170;
	localparam logic [15:0] PAUSE_REFRESH_THRESHOLD_OFFSET = 16'h5F40;

	localparam int CABLE_UNPLUGGED_BIT = 2;
	localparam int PHY_POWER_BIT = 3;
	localparam int XOFF_ON_PAUSE_BIT = 7;
	localparam int CRC_TRIGGER_EN_BIT = 8;
	localparam int RAM_LOCK_EN_BIT = 9;

	localparam int FUNCTION_LSB = 8;
	localparam int DEVICE_LSB = 11;
	localparam int BUS_LSB = 16;
	localparam logic [2:0] FUNCTION_NUMBER = 3'h0;
	localparam logic [4:0] DEVICE_NUMBER = 5'h19;

	localparam logic [2:0] FUTURE_CTRL_RESET = 3'h0;
	localparam logic [7:0] BUS_NUMBER_RESET = 8'h00;
	localparam logic [15:0] PAUSE_TIMER_RESET = 16'h0000;
	localparam logic [15:0] REFRESH_THRESHOLD_RESET = 16'h0000;

	localparam int CLOCK_MHZ = 100;
	localparam int SLOT_BYTE_TIMES = 64;
	// Byte time at 1 Gb/s is 8 ns; slot is 512 ns, rounded down to whole cycles
	localparam int BYTE_TIME_NS = 8;
	localparam int SLOT_CYCLES = (SLOT_BYTE_TIMES * BYTE_TIME_NS * CLOCK_MHZ) / 1000;

	localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
	localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

endpackage : mac_misc_pkg

//--- verification/mac_misc_sva.sv
/* Checker for the misc flow-control register bank.
   Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/100ps
module mac_misc_sva
	import mac_misc_pkg::*;
#(parameter int ADDR_WIDTH = 16) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic lan_reset_n,
	input wire logic crc_mismatch,
	input wire logic crc_hw_offload,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic xoff_request,
	input wire logic crc_mismatch_trigger,
	input wire logic ram_write_lock,
	input wire logic [15:0] pause_slot_pulse
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] gap_reg;
	logic seen_reg;
	// Gap is only judged after a first tick, since the phase after reset is free
	always_ff @(posedge aclk) begin
		gap_reg <= (!aresetn || pause_slot_pulse[0]) ? 8'h00 : gap_reg + 8'h01;
		seen_reg <= aresetn && (seen_reg || pause_slot_pulse[0]);
	end
	trig_cause_a: assert property (crc_mismatch_trigger |-> $past(crc_mismatch) && !$past(crc_hw_offload))
		else $error("trigger without mismatch");
	lock_cause_a: assert property ($rose(ram_write_lock) |-> $past(crc_mismatch))
		else $error("lock without mismatch");
	lock_hold_a: assert property (ram_write_lock && lan_reset_n |=> ram_write_lock)
		else $error("lock dropped");
	lock_clear_a: assert property (!lan_reset_n |=> !ram_write_lock)
		else $error("lock kept over reset");
	slot_gap_a: assert property (seen_reg |-> pause_slot_pulse[0] == (gap_reg == 8'(SLOT_CYCLES - 1)))
		else $error("slot tick spacing");
	slot_width_a: assert property (pause_slot_pulse[15:1] == 15'h0000)
		else $error("slot upper bits set");
	xoff_pulse_a: assert property (xoff_request |=> !xoff_request)
		else $error("xoff request too long");
	dev_num_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == PCI_LOCATION_CAPTURE_OFFSET
		|=> s_axi_rdata[15:8] == {DEVICE_NUMBER, FUNCTION_NUMBER})
		else $error("device number wrong");
	thr_upper_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == PAUSE_REFRESH_THRESHOLD_OFFSET
		|=> s_axi_rdata[31:16] == 16'h0000)
		else $error("threshold upper bits set");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
endmodule : mac_misc_sva
bind mac_misc_flow_ctrl_regs mac_misc_sva #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.*);

//--- verification/xoff_partner.sv
/* Far side: transmit path turning XOFF requests into pause frames.
   Assumes one-cycle requests on aclk; lag above zero. */
`timescale 1ns/100ps
module xoff_partner (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic xoff_request,
	input wire logic [15:0] pause_time_value,
	input wire logic [3:0] lag,
	output logic xoff_sent,
	output logic [15:0] sent_pause_time
);
	logic [3:0] wait_reg;
	always @(posedge aclk) begin
		if (!aresetn) begin
			wait_reg <= 4'h0;
			xoff_sent <= 1'h0;
		end else if (xoff_request === 1'h1) begin
			wait_reg <= lag;
			xoff_sent <= 1'h0;
		end else if (wait_reg != 4'h0) begin
			wait_reg <= wait_reg - 4'h1;
			xoff_sent <= (wait_reg == 4'h1);
			if (wait_reg == 4'h1) begin
				sent_pause_time <= pause_time_value;
			end
		end else begin
			xoff_sent <= 1'h0;
		end
	end
endmodule : xoff_partner

//--- verification/tb_mac_misc_flow_ctrl_regs.sv
/* Bench for the misc flow-control register bank.
   Assumes package, checker and partner model are compiled first. */
`timescale 1ns/100ps
module tb_mac_misc_flow_ctrl_regs
	import mac_misc_pkg::*;
;
	logic aclk = 0, aresetn = 0, lan_reset_n = 1, pci_reset_n = 1, d3_to_d0 = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0, pause_time_value, pause_slot_pulse, sent_pause_time;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, v, t;
	logic [3:0] s_axi_wstrb = 4'hF, lag = 4'h5;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic cable_unplugged_pin = 0, phy_power_pin = 0, cfg_type0_write = 0, crc_mismatch = 0, crc_hw_offload = 0;
	logic tx_paused = 0, rx_above_low_threshold = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, xoff_request, xoff_sent, crc_mismatch_trigger, ram_write_lock;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] cfg_bus_number = 0;
	int n_errors = 0, check_count = 0, trig_n = 0, cyc = 0, last_req = 0, req_gap = 0, hold;
	mac_misc_flow_ctrl_regs dut (.*);
	xoff_partner far_end (.*);
	initial forever #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		trig_n <= trig_n + int'(crc_mismatch_trigger === 1'h1);
		if (xoff_request === 1'h1) begin
			req_gap <= cyc - last_req;
			last_req <= cyc;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		int n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1 && n < 99);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask : wr
	task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		int n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1 && n < 99);
		chk(nm, e, s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : rchk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (30000) @(posedge aclk);
		n_errors++;
		end_sim();
	end
	initial begin
		void'($urandom(83369));
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rchk("ext", FUTURE_EXTENSION_CONTROL_OFFSET, 32'h0, AXI_RESP_OKAY);
		rchk("loc", PCI_LOCATION_CAPTURE_OFFSET, {16'h0, DEVICE_NUMBER, FUNCTION_NUMBER, 8'h00}, AXI_RESP_OKAY);
		rchk("unmapped", 16'h0100, 32'h0, AXI_RESP_SLVERR);
		wr(16'h0100, 32'hFFFFFFFF);
		chk("wresp", 32'(AXI_RESP_SLVERR), 32'(r));
		for (int i = 0; i < 6; i++) begin
			v = $urandom();
			wr(i[0] ? PAUSE_REFRESH_THRESHOLD_OFFSET : PAUSE_TRANSMIT_TIMER_OFFSET, v);
			rchk("rw", i[0] ? PAUSE_REFRESH_THRESHOLD_OFFSET : PAUSE_TRANSMIT_TIMER_OFFSET, {16'h0, v[15:0]}, 0);
		end
		$display("test registers done");
		phy_power_pin <= 1'h1;
		cable_unplugged_pin <= 1'h1;
		repeat (6) @(posedge aclk);
		wr(FUTURE_EXTENSION_CONTROL_OFFSET, 32'h0000038C);
		rchk("ext", FUTURE_EXTENSION_CONTROL_OFFSET, 32'h0000038C, AXI_RESP_OKAY);
		phy_power_pin <= 1'h0;
		pci_reset_n <= 1'h0;
		d3_to_d0 <= 1'h1;
		repeat (6) @(posedge aclk);
		pci_reset_n <= 1'h1;
		d3_to_d0 <= 1'h0;
		rchk("ext", FUTURE_EXTENSION_CONTROL_OFFSET, 32'h00000380, AXI_RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			v = $urandom();
			cfg_bus_number <= v[7:0];
			cfg_type0_write <= 1'h1;
			@(posedge aclk);
			cfg_type0_write <= 1'h0;
			rchk("bus", PCI_LOCATION_CAPTURE_OFFSET, {8'h0, v[7:0], DEVICE_NUMBER, FUNCTION_NUMBER, 8'h00}, 0);
			pci_reset_n <= (k != 0);
			d3_to_d0 <= (k == 1);
			lan_reset_n <= (k != 2);
			@(posedge aclk);
			pci_reset_n <= 1'h1;
			d3_to_d0 <= 1'h0;
			lan_reset_n <= 1'h1;
			rchk("bus", PCI_LOCATION_CAPTURE_OFFSET, {16'h0, DEVICE_NUMBER, FUNCTION_NUMBER, 8'h00}, 0);
		end
		rchk("ext", FUTURE_EXTENSION_CONTROL_OFFSET, 32'h0, AXI_RESP_OKAY);
		$display("test status done");
		wr(FUTURE_EXTENSION_CONTROL_OFFSET, 32'h00000100);
		for (int k = 0; k < 4; k++) begin
			crc_hw_offload <= k[0];
			crc_mismatch <= 1'h1;
			@(posedge aclk);
			crc_mismatch <= 1'h0;
			repeat (3) @(posedge aclk);
		end
		chk("trig", 32'h2, 32'(trig_n));
		chk("lock", 32'h0, 32'(ram_write_lock));
		wr(FUTURE_EXTENSION_CONTROL_OFFSET, 32'h00000200);
		crc_hw_offload <= 1'h0;
		crc_mismatch <= 1'h1;
		@(posedge aclk);
		crc_mismatch <= 1'h0;
		repeat (20) @(posedge aclk);
		chk("lock", 32'h1, 32'(ram_write_lock));
		lan_reset_n <= 1'h0;
		@(posedge aclk);
		lan_reset_n <= 1'h1;
		@(posedge aclk);
		chk("lock", 32'h0, 32'(ram_write_lock));
		$display("test crc done");
		t = $urandom();
		wr(PAUSE_TRANSMIT_TIMER_OFFSET, t);
		rx_above_low_threshold <= 1'h1;
		for (int k = 1; k < 4; k += 2) begin
			lag <= 4'(k * 5);
			wr(PAUSE_REFRESH_THRESHOLD_OFFSET, k);
			repeat (k * 160 + 100) @(posedge aclk);
			chk("gap", 32'(k * SLOT_CYCLES), 32'(req_gap));
		end
		chk("ptime", {16'h0, t[15:0]}, {16'h0, sent_pause_time});
		for (int k = 0; k < 2; k++) begin
			rx_above_low_threshold <= k[0];
			if (k == 1) wr(PAUSE_REFRESH_THRESHOLD_OFFSET, 32'h0);
			repeat (60) @(posedge aclk);
			hold = last_req;
			repeat (300) @(posedge aclk);
			chk("idle", 32'(hold), 32'(last_req));
		end
		wr(PAUSE_TRANSMIT_TIMER_OFFSET, 32'h0);
		wr(FUTURE_EXTENSION_CONTROL_OFFSET, 32'h00000080);
		tx_paused <= 1'h1;
		repeat (200) @(posedge aclk);
		chk("gap", 32'(SLOT_CYCLES), 32'(req_gap));
		chk("ptime", 32'h0, {16'h0, sent_pause_time});
		$display("test refresh done");
		end_sim();
	end
endmodule : tb_mac_misc_flow_ctrl_regs
